// ### design/ftc_pkg.sv
package ftc_pkg;
   // ------------------------------------------------------------
   // register map (printed offsets are indices, byte address = 4x)
   // ------------------------------------------------------------
   localparam logic [7:0]  IDX_SPACE_AMP   = 8'h45;
   localparam logic [7:0]  IDX_SPACE_FREQ  = 8'h46;
   localparam logic [7:0]  IDX_MARK_AMP    = 8'h47;
   localparam logic [7:0]  IDX_MARK_FREQ   = 8'h48;
   localparam logic [7:0]  IDX_S2M_GAIN    = 8'h49;
   localparam logic [7:0]  IDX_M2S_GAIN    = 8'h4A;
   localparam logic [7:0]  IDX_CTRL        = 8'h50;
   localparam logic [7:0]  IDX_TONE_AMP    = 8'h51;
   localparam logic [7:0]  IDX_TONE_FREQ   = 8'h52;
   localparam logic [7:0]  IDX_STATUS      = 8'h53;
   // ------------------------------------------------------------
   // control register fields, reset values and gain format
   // ------------------------------------------------------------
   localparam int          CTRL_MODE_BIT   = 6;
   localparam int          CTRL_RELOAD_BIT = 7;
   localparam logic [15:0] COEFF_RESET     = 16'h0000;
   localparam logic [15:0] GAIN_UNITY      = 16'h4000;
   localparam int          GAIN_FRAC       = 14;

   // reload sent to the tone oscillator
   typedef struct packed {
      logic        valid;
      logic [15:0] amp;
      logic [15:0] freq;
   } ftc_load_t;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_SCALE = 3'b010,
      ST_LOAD  = 3'b100
   } ftc_state_t;
endpackage

// ### design/ftc_gain_mul.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// amplitude times gain factor, 2.14 fixed point, saturating
// ------------------------------------------------------------
module ftc_gain_mul (
   // operands
   input  wire logic [15:0] amp,
   input  wire logic [15:0] gain,
   // result
   output logic      [15:0] scaled
);
   import ftc_pkg::*;
   logic [31:0] prod;
   logic [17:0] shifted;
   // unsigned product, then drop the fraction bits
   assign prod    = amp * gain;
   assign shifted = prod[GAIN_FRAC+17:GAIN_FRAC];
   // clip rather than wrap so a large gain cannot flip the tone
   assign scaled  = (|shifted[17:16]) ? 16'hFFFF : shifted[15:0];
endmodule // ftc_gain_mul

// ### design/ftc_core.sv
// Our own choice: the AHB-Lite register port.
`timescale 1ns/1ps
// How it works
// - symbol coefficients only when both enables set
// - space expiry loads space amplitude coefficient
// - space expiry loads space frequency coefficient
// - mark expiry loads mark amplitude coefficient
// - mark expiry loads mark frequency coefficient
// - space to mark scales amplitude by gain
// - mark to space scales amplitude by gain
module ftc_core (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // oscillator side
   input  wire logic        timerExpire,
   input  wire logic        symbolBit,
   output ftc_pkg::ftc_load_t oscLoad
);
   import ftc_pkg::*;

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic [15:0] spaceAmp_q, spaceFreq_q, markAmp_q, markFreq_q;
   logic [15:0] s2mGain_q, m2sGain_q, toneAmp_q, toneFreq_q;
   logic        modeEn_q, reloadEn_q;
   logic        wrPend_q;
   logic [7:0]  wrIdx_q;
   logic [31:0] hrdata_q;
   logic        lastSym_q, haveSym_q;
   logic [15:0] loadCnt_q;
   ftc_state_t  state_q;
   ftc_load_t   load_q;
   logic [15:0] baseAmp_q, gainSel_q, freqSel_q;
   logic        useGain_q;

   // ------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------
   wire        addrPhase = hsel & hready & htrans[1];
   wire [7:0]  idx       = haddr[9:2];
   wire        rdReq     = addrPhase & ~hwrite;
   wire        wrReq     = addrPhase & hwrite;
   wire        enhanced  = modeEn_q & reloadEn_q;
   wire [15:0] ctrlWord  = 16'((32'(modeEn_q) << CTRL_MODE_BIT)
                              | (32'(reloadEn_q) << CTRL_RELOAD_BIT));
   wire [15:0] statWord  = {13'h0000, lastSym_q, haveSym_q, enhanced};
   logic [15:0] rdMux;
   always_comb begin
      case (idx)
         IDX_SPACE_AMP:  rdMux = spaceAmp_q;
         IDX_SPACE_FREQ: rdMux = spaceFreq_q;
         IDX_MARK_AMP:   rdMux = markAmp_q;
         IDX_MARK_FREQ:  rdMux = markFreq_q;
         IDX_S2M_GAIN:   rdMux = s2mGain_q;
         IDX_M2S_GAIN:   rdMux = m2sGain_q;
         IDX_CTRL:       rdMux = ctrlWord;
         IDX_TONE_AMP:   rdMux = toneAmp_q;
         IDX_TONE_FREQ:  rdMux = toneFreq_q;
         IDX_STATUS:     rdMux = statWord;
         default:        rdMux = 16'h0000; // unmapped reads zero
      endcase
   end

   // write address captured in the address phase, data in the next
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wrPend_q <= 1'b0;
         wrIdx_q  <= 8'h00;
         hrdata_q <= 32'h0000_0000;
      end else begin
         wrPend_q <= wrReq;
         if (wrReq) wrIdx_q <= idx;
         if (rdReq) hrdata_q <= {16'h0000, rdMux};
      end
   end

   // register writes; unmapped writes are dropped
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         spaceAmp_q  <= COEFF_RESET;
         spaceFreq_q <= COEFF_RESET;
         markAmp_q   <= COEFF_RESET;
         markFreq_q  <= COEFF_RESET;
         s2mGain_q   <= GAIN_UNITY;
         m2sGain_q   <= GAIN_UNITY;
         toneAmp_q   <= COEFF_RESET;
         toneFreq_q  <= COEFF_RESET;
         modeEn_q    <= 1'b0;
         reloadEn_q  <= 1'b0;
      end else if (wrPend_q) begin
         case (wrIdx_q)
            IDX_SPACE_AMP:  spaceAmp_q  <= hwdata[15:0];
            IDX_SPACE_FREQ: spaceFreq_q <= hwdata[15:0];
            IDX_MARK_AMP:   markAmp_q   <= hwdata[15:0];
            IDX_MARK_FREQ:  markFreq_q  <= hwdata[15:0];
            IDX_S2M_GAIN:   s2mGain_q   <= hwdata[15:0];
            IDX_M2S_GAIN:   m2sGain_q   <= hwdata[15:0];
            IDX_TONE_AMP:   toneAmp_q   <= hwdata[15:0];
            IDX_TONE_FREQ:  toneFreq_q  <= hwdata[15:0];
            IDX_CTRL: begin
               modeEn_q   <= hwdata[CTRL_MODE_BIT];
               reloadEn_q <= hwdata[CTRL_RELOAD_BIT];
            end
            default: ;
         endcase
      end
   end

   // ------------------------------------------------------------
   // reload selection on timer expiry
   // ------------------------------------------------------------
   wire        isMark   = symbolBit;
   wire        toMark   = haveSym_q & ~lastSym_q & isMark;
   wire        toSpace  = haveSym_q & lastSym_q & ~isMark;
   wire [15:0] symAmp   = isMark ? markAmp_q : spaceAmp_q;
   wire [15:0] symFreq  = isMark ? markFreq_q : spaceFreq_q;
   wire [15:0] selAmp   = enhanced ? symAmp : toneAmp_q;
   wire [15:0] selFreq  = enhanced ? symFreq : toneFreq_q;
   wire [15:0] selGain  = toMark ? s2mGain_q : m2sGain_q;
   wire        selUse   = enhanced & (toMark | toSpace);
   wire [15:0] scaledAmp;

   ftc_gain_mul u_mul (
      .amp    (baseAmp_q),
      .gain   (gainSel_q),
      .scaled (scaledAmp)
   );

   // expiry captured in one cycle, scaled and presented in the next;
   // an expiry during the scale cycle is not accepted
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_q   <= ST_IDLE;
         load_q    <= '0;
         baseAmp_q <= 16'h0000;
         gainSel_q <= GAIN_UNITY;
         freqSel_q <= 16'h0000;
         useGain_q <= 1'b0;
         lastSym_q <= 1'b0;
         haveSym_q <= 1'b0;
         loadCnt_q <= 16'h0000;
      end else begin
         load_q.valid <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               if (timerExpire) begin
                  baseAmp_q <= selAmp;
                  freqSel_q <= selFreq;
                  gainSel_q <= selGain;
                  useGain_q <= selUse;
                  lastSym_q <= isMark;
                  haveSym_q <= enhanced;
                  state_q   <= ST_SCALE;
               end
            end
            ST_SCALE: begin
               load_q.valid <= 1'b1;
               load_q.amp   <= useGain_q ? scaledAmp : baseAmp_q;
               load_q.freq  <= freqSel_q;
               loadCnt_q    <= loadCnt_q + 16'h0001;
               state_q      <= ST_IDLE;
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign oscLoad   = load_q;
   assign hrdata    = hrdata_q;
   assign hreadyout = 1'b1;  // zero wait states, constant ready
   assign hresp     = 1'b0;  // always okay

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   logic        prevEn_q, prevMark_q, prevHave_q;
   logic [15:0] pSA_q, pSF_q, pMA_q, pMF_q, pTA_q, pTF_q;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         prevEn_q <= 1'b0; prevMark_q <= 1'b0; prevHave_q <= 1'b0;
         pSA_q <= 16'h0000; pSF_q <= 16'h0000; pMA_q <= 16'h0000;
         pMF_q <= 16'h0000; pTA_q <= 16'h0000; pTF_q <= 16'h0000;
      end else if (state_q == ST_IDLE && timerExpire) begin
         prevEn_q <= enhanced; prevMark_q <= isMark;
         prevHave_q <= toMark | toSpace;
         pSA_q <= spaceAmp_q; pSF_q <= spaceFreq_q; pMA_q <= markAmp_q;
         pMF_q <= markFreq_q; pTA_q <= toneAmp_q; pTF_q <= toneFreq_q;
      end
   end

   load_follows_a: assert property (@(posedge clk_sys) disable iff (rst)
      (state_q == ST_IDLE && timerExpire) |-> ##2 oscLoad.valid)
      else $error("reload not issued two cycles after expiry");
   space_amp_a: assert property (@(posedge clk_sys) disable iff (rst)
      $rose(oscLoad.valid) && prevEn_q && !prevMark_q && !prevHave_q
      |-> oscLoad.amp == pSA_q) else $error("space amplitude wrong");
   space_freq_a: assert property (@(posedge clk_sys) disable iff (rst)
      oscLoad.valid && prevEn_q && !prevMark_q |-> oscLoad.freq == pSF_q)
      else $error("space frequency wrong");
   mark_amp_a: assert property (@(posedge clk_sys) disable iff (rst)
      oscLoad.valid && prevEn_q && prevMark_q && !prevHave_q
      |-> oscLoad.amp == pMA_q) else $error("mark amplitude wrong");
   mark_freq_a: assert property (@(posedge clk_sys) disable iff (rst)
      oscLoad.valid && prevEn_q && prevMark_q |-> oscLoad.freq == pMF_q)
      else $error("mark frequency wrong");
   rise_gain_a: assert property (@(posedge clk_sys) disable iff (rst)
      (state_q == ST_IDLE && timerExpire && enhanced && toMark)
      |=> useGain_q && gainSel_q == s2mGain_q) else $error("rise gain unused");
   fall_gain_a: assert property (@(posedge clk_sys) disable iff (rst)
      (state_q == ST_IDLE && timerExpire && enhanced && toSpace)
      |=> useGain_q && gainSel_q == m2sGain_q) else $error("fall gain unused");
   plain_load_a: assert property (@(posedge clk_sys) disable iff (rst)
      oscLoad.valid && !prevEn_q |-> oscLoad.amp == pTA_q && oscLoad.freq == pTF_q)
      else $error("ordinary reload wrong");
   zero_wait_a: assert property (@(posedge clk_sys) disable iff (rst)
      hreadyout && !hresp) else $error("bus not ready or error");

   enh_cov: cover property (@(posedge clk_sys) disable iff (rst)
      oscLoad.valid && prevEn_q);
   rise_cov: cover property (@(posedge clk_sys) disable iff (rst)
      state_q == ST_SCALE && useGain_q && lastSym_q);
   fall_cov: cover property (@(posedge clk_sys) disable iff (rst)
      state_q == ST_SCALE && useGain_q && !lastSym_q);
   plain_cov: cover property (@(posedge clk_sys) disable iff (rst)
      oscLoad.valid && !prevEn_q);
   steady_cov: cover property (@(posedge clk_sys) disable iff (rst)
      oscLoad.valid && prevEn_q && !prevHave_q);

   // ------------------------------------------------------------
   // reference for the scaled amplitude checks
   // ------------------------------------------------------------
   // the gain is captured from the raw registers, so a broken select
   // in the datapath shows up here; the symbol history is shared with it
   logic [15:0] pGain_q;
   logic [31:0] refProd;
   logic [15:0] refBase;
   logic [15:0] refAmp;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pGain_q <= GAIN_UNITY;
      end else if (state_q == ST_IDLE && timerExpire) begin
         pGain_q <= isMark ? s2mGain_q : m2sGain_q;
      end
   end
   assign refBase = prevMark_q ? pMA_q : pSA_q;
   assign refProd = refBase * pGain_q;
   // saturate like the multiplier, so a clipped load is still expected
   assign refAmp  = (|refProd[31:30]) ? 16'hFFFF : refProd[29:14];

   rise_amp_a: assert property (@(posedge clk_sys) disable iff (rst)
      oscLoad.valid && prevEn_q && prevMark_q && prevHave_q
      |-> oscLoad.amp == refAmp) else $error("rise amplitude not scaled");
   fall_amp_a: assert property (@(posedge clk_sys) disable iff (rst)
      oscLoad.valid && prevEn_q && !prevMark_q && prevHave_q
      |-> oscLoad.amp == refAmp) else $error("fall amplitude not scaled");
   plain_nogain_a: assert property (@(posedge clk_sys) disable iff (rst)
      (state_q == ST_IDLE && timerExpire && !enhanced) |=> !useGain_q)
      else $error("gain applied outside enhanced mode");
   hist_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
      (state_q == ST_IDLE && timerExpire && !enhanced) |=> !haveSym_q)
      else $error("symbol history kept while disabled");
   valid_pulse_a: assert property (@(posedge clk_sys) disable iff (rst)
      oscLoad.valid |=> !oscLoad.valid)
      else $error("reload strobe longer than one cycle");
   busy_drop_a: assert property (@(posedge clk_sys) disable iff (rst)
      state_q == ST_SCALE |=> state_q == ST_IDLE)
      else $error("scale cycle did not return to idle");
   load_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
      !oscLoad.valid |-> $stable(oscLoad.amp) && $stable(oscLoad.freq))
      else $error("reload value moved without strobe");
   ctrl_commit_a: assert property (@(posedge clk_sys) disable iff (rst)
      wrPend_q && wrIdx_q == IDX_CTRL
      |=> modeEn_q == $past(hwdata[CTRL_MODE_BIT])
          && reloadEn_q == $past(hwdata[CTRL_RELOAD_BIT]))
      else $error("control write not committed");
   space_commit_a: assert property (@(posedge clk_sys) disable iff (rst)
      wrPend_q && wrIdx_q == IDX_SPACE_AMP
      |=> spaceAmp_q == $past(hwdata[15:0]))
      else $error("space amplitude write not committed");
   mark_commit_a: assert property (@(posedge clk_sys) disable iff (rst)
      wrPend_q && wrIdx_q == IDX_MARK_AMP
      |=> markAmp_q == $past(hwdata[15:0]))
      else $error("mark amplitude write not committed");
   rd_upper_a: assert property (@(posedge clk_sys) disable iff (rst)
      hrdata[31:16] == 16'h0000) else $error("read data upper half not zero");
endmodule // ftc_core

// ### tb/testbench.sv
`timescale 1ns/1ps
module testbench;
   import ftc_pkg::*;
   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   logic               clk_sys;
   logic               rst;
   logic               hsel;
   logic        [31:0] haddr;
   logic        [1:0]  htrans;
   logic               hwrite;
   logic        [2:0]  hsize;
   logic        [31:0] hwdata;
   logic               hready;
   logic        [31:0] hrdata;
   logic               hreadyout;
   logic               hresp;
   logic               timerExpire;
   logic               symbolBit;
   ftc_load_t          oscLoad;
   logic        [31:0] rdv;
   int                 nFail;
   int                 testsRun;

   // single slave, so its ready is the bus ready
   assign hready = hreadyout;

   ftc_core ftc_core_inst (
      .clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .timerExpire(timerExpire), .symbolBit(symbolBit), .oscLoad(oscLoad)
   );

   always #4 clk_sys = ~clk_sys;

   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic stopTest();
      $display("comparisons %0d mismatches %0d", testsRun, nFail);
      if (nFail == 0 && testsRun > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      testsRun++;
      if (seen !== exp) begin
         nFail++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // bounded wait for ready; a hung bus ends the run
   task automatic waitRdy();
      int k;
      k = 0;
      do begin
         @(posedge clk_sys);
         k++;
      end while (hready !== 1'b1 && k < 20);
      if (hready !== 1'b1) begin
         nFail++;
         stopTest();
      end
   endtask

   // one single word transfer, address phase then data phase
   task automatic bus(input logic wr, input logic [7:0] idx, input logic [15:0] wd,
                      output logic [31:0] rd);
      htrans <= 2'b10;
      hsel   <= 1'b1;
      hwrite <= wr;
      haddr  <= {22'h00_0000, idx, 2'b00};
      waitRdy();
      htrans <= 2'b00;
      hsel   <= 1'b0;
      hwdata <= {16'h0000, wd};
      waitRdy();
      rd = hrdata;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [15:0] v);
      bus(1'b1, idx, v, rdv);
   endtask

   task automatic rdChk(input logic [7:0] idx, input logic [15:0] v);
      bus(1'b0, idx, 16'h0000, rdv);
      chk(rdv, {16'h0000, v});
   endtask

   // one expiry pulse, then wait a few edges for the reload
   task automatic expire(input logic sym, input logic [15:0] a, input logic [15:0] f);
      int k;
      timerExpire <= 1'b1;
      symbolBit   <= sym;
      @(posedge clk_sys);
      timerExpire <= 1'b0;
      k = 0;
      do begin
         @(posedge clk_sys);
         k++;
      end while (oscLoad.valid !== 1'b1 && k < 8);
      // a reload that never comes ends the run at the closing report
      if (oscLoad.valid !== 1'b1) begin
         nFail++;
         stopTest();
      end
      chk({31'h0000_0000, oscLoad.valid}, 32'h0000_0001);
      chk({oscLoad.amp, oscLoad.freq}, {a, f});
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic resetScn();
      for (int i = 0; i < 4; i++) rdChk(IDX_SPACE_AMP + 8'(i), COEFF_RESET);
      rdChk(IDX_S2M_GAIN, GAIN_UNITY);
      rdChk(IDX_M2S_GAIN, GAIN_UNITY);
      chk({31'h0000_0000, hresp}, 32'h0000_0000);
   endtask

   // distinct pattern per register; unmapped place stays zero
   task automatic rwScn();
      for (int i = 0; i < 6; i++) wr(IDX_SPACE_AMP + 8'(i), {8'hA5, IDX_SPACE_AMP + 8'(i)});
      for (int i = 0; i < 6; i++) rdChk(IDX_SPACE_AMP + 8'(i), {8'hA5, IDX_SPACE_AMP + 8'(i)});
      wr(8'h60, 16'hBEEF);
      rdChk(8'h60, 16'h0000);
   endtask

   // either enable alone must leave ordinary reload in charge
   task automatic legacyScn();
      wr(IDX_TONE_AMP, 16'h1111);
      wr(IDX_TONE_FREQ, 16'h2222);
      wr(IDX_CTRL, 16'h0000);
      expire(1'b0, 16'h1111, 16'h2222);
      wr(IDX_CTRL, 16'h0040);
      expire(1'b1, 16'h1111, 16'h2222);
      wr(IDX_CTRL, 16'h0080);
      expire(1'b0, 16'h1111, 16'h2222);
   endtask

   // gains in 2.14: 0x8000 doubles, 0x2000 halves
   task automatic enhScn();
      wr(IDX_SPACE_AMP, 16'h0100);
      wr(IDX_SPACE_FREQ, 16'h0AAA);
      wr(IDX_MARK_AMP, 16'h1234);
      wr(IDX_MARK_FREQ, 16'h0BBB);
      wr(IDX_S2M_GAIN, 16'h8000);
      wr(IDX_M2S_GAIN, 16'h2000);
      wr(IDX_CTRL, 16'h00C0);
      expire(1'b0, 16'h0100, 16'h0AAA);
      expire(1'b1, 16'h2468, 16'h0BBB);
      expire(1'b1, 16'h1234, 16'h0BBB);
      expire(1'b0, 16'h0080, 16'h0AAA);
      expire(1'b0, 16'h0100, 16'h0AAA);
      wr(IDX_CTRL, 16'h0000);
      expire(1'b1, 16'h1111, 16'h2222);
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      clk_sys     = 1'b0;
      rst         = 1'b1;
      hsel        = 1'b0;
      haddr       = 32'h0000_0000;
      htrans      = 2'b00;
      hwrite      = 1'b0;
      hsize       = 3'b010;
      hwdata      = 32'h0000_0000;
      timerExpire = 1'b0;
      symbolBit   = 1'b0;
      nFail       = 0;
      testsRun    = 0;
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      resetScn();
      rwScn();
      legacyScn();
      enhScn();
      stopTest();
   end
endmodule // testbench
